/* verilog/adc_mode_pkg.sv */
// package: register map, mode codes, field positions and timing for mode control
package adc_mode_pkg;
  // register byte addresses (word index * 4)
  localparam logic [3:0] addr_config = 4'h0;
  localparam logic [3:0] addr_status = 4'h4;
  localparam logic [3:0] addr_irq_status = 4'h8;
  localparam logic [3:0] addr_irq_mask = 4'hC;
  localparam logic [3:0] addr_cal_result = 4'h0;
  // configuration field positions
  localparam int mode_hi = 15;
  localparam int mode_lo = 13;
  localparam int polarity_bit = 12;
  localparam int port_output_enable_bit = 11;
  localparam int port_value_bit1_pos = 10;
  localparam int port_value_bit0_pos = 9;
  localparam int channel_select_high_pos = 1;
  localparam int channel_select_low_pos = 0;
  localparam logic [15:0] config_reset = 16'h01B0;
  // status layout
  localparam int status_ready_n = 0;
  localparam int status_standby = 1;
  localparam int status_idle = 2;
  localparam int status_busy = 3;
  // interrupt status bits
  localparam int irq_cal_start = 0;
  localparam int irq_cal_done = 1;
  localparam int irq_width = 2;
  // mode codes
  localparam logic [2:0] mode_idle = 3'h0;
  localparam logic [2:0] mode_continuous = 3'h1;
  localparam logic [2:0] mode_single = 3'h2;
  localparam logic [2:0] mode_standby = 3'h3;
  localparam logic [2:0] mode_zero_self = 3'h4;
  localparam logic [2:0] mode_full_self = 3'h5;
  localparam logic [2:0] mode_zero_system = 3'h6;
  localparam logic [2:0] mode_full_system = 3'h7;
  // calibration duration
  localparam int cal_time_us = 100;
  localparam int clk_mhz = 40;
  localparam int cal_cycles = cal_time_us * clk_mhz;
  // controller states
  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_cal = 3'b010,
    st_run = 3'b100
  } ctrl_state_type;
endpackage

/* verilog/pin_sync.sv */
// three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
module pin_sync (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // pin and filtered level
  input wire logic pin_in,
  output logic level
);
  logic [2:0] stage_reg;
  logic [2:0] stage_next;
  logic level_reg;
  logic level_next;

  always_comb begin
    stage_next = {stage_reg[1:0], pin_in};
    level_next = level_reg;
    // first stage feeds only the second
    if (stage_reg[1] == stage_reg[2]) begin
      level_next = stage_reg[2];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stage_reg <= 3'h0;
      level_reg <= 1'b0;
    end else begin
      stage_reg <= stage_next;
      level_reg <= level_next;
    end
  end

  assign level = level_reg;
endmodule

/* verilog/cal_timer.sv */
// calibration duration counter, at most one done pulse per start
`timescale 1ns/1ps
module cal_timer #(
  parameter int cycles = adc_mode_pkg::cal_cycles
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // control
  input wire logic start,
  input wire logic abort,
  output logic done
);
  logic [31:0] count_reg;
  logic [31:0] count_next;
  logic run_reg;
  logic run_next;
  logic done_reg;
  logic done_next;

  always_comb begin
    count_next = count_reg;
    run_next = run_reg;
    done_next = 1'b0;
    // a calibration written over a calibration restarts, never stalls
    if (start) begin
      run_next = 1'b1;
      count_next = 32'h0;
    end else if (abort) begin
      run_next = 1'b0;
    end else if (run_reg) begin
      if (count_reg == 32'(cycles - 1)) begin
        run_next = 1'b0;
        done_next = 1'b1;
      end else begin
        count_next = count_reg + 32'h1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      count_reg <= 32'h0;
      run_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      run_reg <= run_next;
      done_reg <= done_next;
    end
  end

  assign done = done_reg;
endmodule

/* verilog/adc_mode_calibration_control.sv */
// mode register, calibration sequencing, coding select and port pins
`timescale 1ns/1ps
module adc_mode_calibration_control #(
  parameter int cal_cycles = adc_mode_pkg::cal_cycles
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic irq,
  // external standby pin
  input wire logic standby_pin,
  // converter core control
  output logic power_down,
  output logic modulator_reset,
  output logic convert_enable,
  output logic [1:0] cal_channel,
  output logic cal_zero_input,
  output logic cal_full_input,
  output logic offset_update,
  output logic gain_update,
  output logic unipolar_coding,
  output logic ready_n,
  // shared second-channel pins
  output logic shared_pin_port_bit1_o,
  output logic shared_pin_port_bit1_oe,
  output logic shared_pin_port_bit0_o,
  output logic shared_pin_port_bit0_oe
);
  // ----------------------------------------
  // output word layout
  // ----------------------------------------
  // all core control and port pin outputs share one flop stage in out_reg
  localparam int ready_n_pos = 0;
  localparam int power_down_pos = 1;
  localparam int mod_reset_pos = 2;
  localparam int convert_pos = 3;
  localparam int chan_lo_pos = 4;
  localparam int chan_hi_pos = 5;
  localparam int zero_in_pos = 6;
  localparam int full_in_pos = 7;
  localparam int offset_upd_pos = 8;
  localparam int gain_upd_pos = 9;
  localparam int unipolar_pos = 10;
  localparam int port_oe_pos = 11;
  localparam int port_bit1_pos = 12;
  localparam int port_bit0_pos = 13;
  // modulator held in reset from the first cycle
  localparam logic [15:0] out_reset = 16'h0001 << mod_reset_pos;

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [15:0] config_reg;
  logic [15:0] config_next;
  adc_mode_pkg::ctrl_state_type state_reg;
  adc_mode_pkg::ctrl_state_type state_next;
  logic [2:0] cal_mode_reg;
  logic [2:0] cal_mode_next;
  logic [1:0] irq_status_reg;
  logic [1:0] irq_status_next;
  logic [1:0] irq_mask_reg;
  logic [1:0] irq_mask_next;
  logic [31:0] readdata_reg;
  logic [31:0] readdata_next;
  logic ack_reg;
  logic ack_next;
  logic waitrequest_reg;
  logic waitrequest_next;
  logic [15:0] out_reg;
  logic [15:0] out_next;
  logic irq_reg;
  logic irq_next;
  logic standby_level;
  logic cal_start;
  logic cal_done;
  logic bus_write;
  logic [2:0] mode_field;
  logic [2:0] new_mode;
  logic [15:0] written;
  logic [1:0] irq_set;

  pin_sync u_standby_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin_in(standby_pin),
    .level(standby_level)
  );

  cal_timer #(
    .cycles(cal_cycles)
  ) u_cal_timer (
    .clk_sys(clk_sys),
    .rst(rst),
    .start(cal_start),
    .abort(bus_write && (address == adc_mode_pkg::addr_config) && state_reg == adc_mode_pkg::st_cal),
    .done(cal_done)
  );

  // ----------------------------------------
  // bus and mode register
  // ----------------------------------------
  // one wait cycle per access keeps readdata registered
  assign bus_write = write && !ack_reg;
  assign mode_field = config_reg[adc_mode_pkg::mode_hi:adc_mode_pkg::mode_lo];

  always_comb begin
    written = config_reg;
    if (byteenable[0]) begin
      written[7:0] = writedata[7:0];
    end
    if (byteenable[1]) begin
      written[15:8] = writedata[15:8];
    end
    new_mode = written[adc_mode_pkg::mode_hi:adc_mode_pkg::mode_lo];
  end

  assign cal_start = bus_write && (address == adc_mode_pkg::addr_config) && new_mode[2];

  always_comb begin
    config_next = config_reg;
    state_next = state_reg;
    cal_mode_next = cal_mode_reg;
    irq_mask_next = irq_mask_reg;
    irq_set = 2'h0;
    ack_next = (read || write) && !ack_reg;
    // stall kept in its own flop so the port needs no inverter
    waitrequest_next = !ack_next;
    readdata_next = readdata_reg;
    if (cal_done && state_reg == adc_mode_pkg::st_cal) begin
      config_next[adc_mode_pkg::mode_hi:adc_mode_pkg::mode_lo] = adc_mode_pkg::mode_idle;
      state_next = adc_mode_pkg::st_idle;
      irq_set[adc_mode_pkg::irq_cal_done] = 1'b1;
    end
    if (bus_write) begin
      case (address)
        adc_mode_pkg::addr_config: begin
          // new mode replaces any mode in progress
          config_next = written;
          if (new_mode[2]) begin
            state_next = adc_mode_pkg::st_cal;
            cal_mode_next = new_mode;
            irq_set[adc_mode_pkg::irq_cal_start] = 1'b1;
          end else if (new_mode == adc_mode_pkg::mode_continuous ||
                       new_mode == adc_mode_pkg::mode_single) begin
            state_next = adc_mode_pkg::st_run;
          end else begin
            state_next = adc_mode_pkg::st_idle;
          end
        end
        adc_mode_pkg::addr_irq_mask: begin
          irq_mask_next = writedata[1:0];
        end
        default: begin
        end
      endcase
    end
    if (read && !ack_reg) begin
      case (address)
        adc_mode_pkg::addr_config: readdata_next = {16'h0, config_reg};
        adc_mode_pkg::addr_status: begin
          readdata_next = 32'h0;
          // ready and standby status bits mirror the output flops, idle and busy come from state_reg
          readdata_next[adc_mode_pkg::status_ready_n] = out_reg[ready_n_pos];
          readdata_next[adc_mode_pkg::status_standby] = out_reg[power_down_pos];
          readdata_next[adc_mode_pkg::status_idle] = state_reg == adc_mode_pkg::st_idle;
          readdata_next[adc_mode_pkg::status_busy] = state_reg == adc_mode_pkg::st_cal;
        end
        adc_mode_pkg::addr_irq_status: readdata_next = {30'h0, irq_status_reg};
        adc_mode_pkg::addr_irq_mask: readdata_next = {30'h0, irq_mask_reg};
        default: readdata_next = 32'h0;
      endcase
    end
    // set wins over write-one-to-clear
    irq_status_next = irq_status_reg;
    if (bus_write && address == adc_mode_pkg::addr_irq_status) begin
      irq_status_next = irq_status_reg & ~writedata[1:0];
    end
    irq_status_next = irq_status_next | irq_set;
    irq_next = |(irq_status_next & irq_mask_next);
  end

  // ----------------------------------------
  // derived core controls
  // ----------------------------------------
  always_comb begin
    out_next = 16'h0000;
    out_next[ready_n_pos] = state_next == adc_mode_pkg::st_cal;
    out_next[power_down_pos] = (config_next[adc_mode_pkg::mode_hi:adc_mode_pkg::mode_lo] ==
                                adc_mode_pkg::mode_standby) || standby_level;
    out_next[mod_reset_pos] = state_next == adc_mode_pkg::st_idle || out_next[power_down_pos];
    out_next[convert_pos] = state_next == adc_mode_pkg::st_run && !out_next[power_down_pos];
    out_next[chan_hi_pos] = config_next[adc_mode_pkg::channel_select_high_pos];
    out_next[chan_lo_pos] = config_next[adc_mode_pkg::channel_select_low_pos];
    out_next[zero_in_pos] = state_next == adc_mode_pkg::st_cal &&
                            cal_mode_next == adc_mode_pkg::mode_zero_self;
    out_next[full_in_pos] = state_next == adc_mode_pkg::st_cal &&
                            cal_mode_next == adc_mode_pkg::mode_full_self;
    // update pulses only from a timer end, never on abort
    if (cal_done && state_reg == adc_mode_pkg::st_cal) begin
      out_next[offset_upd_pos] = cal_mode_reg == adc_mode_pkg::mode_zero_self ||
                                 cal_mode_reg == adc_mode_pkg::mode_full_self ||
                                 cal_mode_reg == adc_mode_pkg::mode_zero_system;
      out_next[gain_upd_pos] = cal_mode_reg == adc_mode_pkg::mode_full_self ||
                               cal_mode_reg == adc_mode_pkg::mode_full_system;
    end
    out_next[unipolar_pos] = config_next[adc_mode_pkg::polarity_bit];
    out_next[port_oe_pos] = config_next[adc_mode_pkg::port_output_enable_bit];
    out_next[port_bit1_pos] = config_next[adc_mode_pkg::port_value_bit1_pos] &&
                              out_next[port_oe_pos];
    out_next[port_bit0_pos] = config_next[adc_mode_pkg::port_value_bit0_pos] &&
                              out_next[port_oe_pos];
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      config_reg <= adc_mode_pkg::config_reset;
      state_reg <= adc_mode_pkg::st_idle;
      cal_mode_reg <= adc_mode_pkg::mode_idle;
      irq_status_reg <= 2'h0;
      irq_mask_reg <= 2'h0;
      readdata_reg <= 32'h0;
      ack_reg <= 1'b0;
      waitrequest_reg <= 1'b1;
      out_reg <= out_reset;
      irq_reg <= 1'b0;
    end else begin
      config_reg <= config_next;
      state_reg <= state_next;
      cal_mode_reg <= cal_mode_next;
      irq_status_reg <= irq_status_next;
      irq_mask_reg <= irq_mask_next;
      readdata_reg <= readdata_next;
      ack_reg <= ack_next;
      waitrequest_reg <= waitrequest_next;
      out_reg <= out_next;
      irq_reg <= irq_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign readdata = readdata_reg;
  assign waitrequest = waitrequest_reg;
  assign irq = irq_reg;
  assign ready_n = out_reg[ready_n_pos];
  assign power_down = out_reg[power_down_pos];
  assign modulator_reset = out_reg[mod_reset_pos];
  assign convert_enable = out_reg[convert_pos];
  assign cal_channel = {out_reg[chan_hi_pos], out_reg[chan_lo_pos]};
  assign cal_zero_input = out_reg[zero_in_pos];
  assign cal_full_input = out_reg[full_in_pos];
  assign offset_update = out_reg[offset_upd_pos];
  assign gain_update = out_reg[gain_upd_pos];
  assign unipolar_coding = out_reg[unipolar_pos];
  // one enable bit drives both shared pins
  assign shared_pin_port_bit1_oe = out_reg[port_oe_pos];
  assign shared_pin_port_bit0_oe = out_reg[port_oe_pos];
  assign shared_pin_port_bit1_o = out_reg[port_bit1_pos];
  assign shared_pin_port_bit0_o = out_reg[port_bit0_pos];
endmodule

/* testbench/adc_mode_checker.sv */
// checker: port-level relations of the mode and calibration control
`timescale 1ns/1ps
module adc_mode_checker #(
  parameter int cal_cycles = 20
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  input wire logic standby_pin,
  input wire logic power_down,
  input wire logic modulator_reset,
  input wire logic convert_enable,
  input wire logic cal_zero_input,
  input wire logic cal_full_input,
  input wire logic offset_update,
  input wire logic gain_update,
  input wire logic ready_n,
  input wire logic shared_pin_port_bit1_o,
  input wire logic shared_pin_port_bit1_oe,
  input wire logic shared_pin_port_bit0_o,
  input wire logic shared_pin_port_bit0_oe
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  // ready falls cal_cycles+1 edges after its rise, seven taken by the repeat
  localparam int cal_lo = cal_cycles - 6;
  localparam int cal_hi = cal_cycles - 6;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_cal_start;
    $rose(ready_n);
  endsequence
  sequence s_cal_end;
    $fell(ready_n);
  endsequence
  property p_answer;
    (read || write) && waitrequest |=> !waitrequest;
  endproperty
  property p_pin_standby;
    standby_pin [*8] |=> power_down;
  endproperty
  property p_idle_hold;
    modulator_reset |-> !convert_enable;
  endproperty
  property p_oe_pair;
    shared_pin_port_bit1_oe == shared_pin_port_bit0_oe;
  endproperty
  property p_port_off;
    !shared_pin_port_bit1_oe |-> !shared_pin_port_bit1_o && !shared_pin_port_bit0_o;
  endproperty
  property p_end_pulse;
    offset_update || gain_update |-> s_cal_end;
  endproperty
  property p_cal_span;
    s_cal_start |-> ready_n [*8] ##[cal_lo:cal_hi] s_cal_end;
  endproperty
  property p_gain_once;
    gain_update |=> !gain_update && !ready_n;
  endproperty
  property p_zero_input;
    cal_zero_input |-> ready_n && !cal_full_input;
  endproperty
  a_answer: assert property (p_answer) else $error("no answer one cycle after request");
  a_pin_standby: assert property (p_pin_standby) else $error("pin held, no power down");
  a_idle_hold: assert property (p_idle_hold) else $error("converting while held");
  a_oe_pair: assert property (p_oe_pair) else $error("pin enables differ");
  a_port_off: assert property (p_port_off) else $error("pin level while disabled");
  a_end_pulse: assert property (p_end_pulse) else $error("update without ready fall");
  a_cal_span: assert property (p_cal_span) else $error("calibration length wrong");
  a_gain_once: assert property (p_gain_once) else $error("gain update not single");
  a_zero_input: assert property (p_zero_input) else $error("zero input outside cal");
endmodule

/* testbench/avalon_host_model.sv */
// host model: avalon-mm master with bounded waits
`timescale 1ns/1ps
module avalon_host_model (
  input wire logic clk_sys,
  input wire logic waitrequest,
  input wire logic [31:0] readdata,
  output logic [3:0] address,
  output logic read,
  output logic write,
  output logic [31:0] writedata,
  output logic [3:0] byteenable
);
  initial begin
    address = 4'h0;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    byteenable = 4'h0;
  end
  // request held until waitrequest sampled low
  task automatic xfer(input logic [3:0] a, input logic wr, input logic [31:0] d,
                      input logic [3:0] be, output logic [31:0] q, output logic ok);
    ok = 1'b0;
    @(posedge clk_sys);
    address <= a;
    read <= !wr;
    write <= wr;
    writedata <= d;
    byteenable <= be;
    for (int k = 0; k < 50 && !ok; k++) begin
      @(posedge clk_sys);
      ok = (waitrequest === 1'b0);
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    // released data turned over so a stale value never looks valid
    writedata <= ~d;
  endtask
endmodule

/* testbench/adc_mode_calibration_control_tb_top.sv */
// bench top: registers, calibration modes, standby, coding, port pins
`timescale 1ns/1ps
module adc_mode_calibration_control_tb_top;
  localparam int cal_n = 20;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic standby_pin = 1'b0;
  logic [3:0] address;
  logic read;
  logic write;
  logic [31:0] writedata;
  logic [3:0] byteenable;
  logic [31:0] readdata;
  logic waitrequest;
  logic irq;
  logic power_down;
  logic modulator_reset;
  logic convert_enable;
  logic [1:0] cal_channel;
  logic cal_zero_input;
  logic cal_full_input;
  logic offset_update;
  logic gain_update;
  logic unipolar_coding;
  logic ready_n;
  logic p1_o;
  logic p1_oe;
  logic p0_o;
  logic p0_oe;
  logic saw_offset = 1'b0;
  logic saw_gain = 1'b0;
  int n_mismatch = 0;
  int samples_checked = 0;
  always #12.5 clk_sys = ~clk_sys;
  adc_mode_calibration_control #(.cal_cycles(cal_n)) u_dut (
    .clk_sys(clk_sys), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .irq(irq), .standby_pin(standby_pin),
    .power_down(power_down), .modulator_reset(modulator_reset),
    .convert_enable(convert_enable), .cal_channel(cal_channel),
    .cal_zero_input(cal_zero_input), .cal_full_input(cal_full_input),
    .offset_update(offset_update), .gain_update(gain_update),
    .unipolar_coding(unipolar_coding), .ready_n(ready_n),
    .shared_pin_port_bit1_o(p1_o), .shared_pin_port_bit1_oe(p1_oe),
    .shared_pin_port_bit0_o(p0_o), .shared_pin_port_bit0_oe(p0_oe));
  avalon_host_model u_host (
    .clk_sys(clk_sys), .waitrequest(waitrequest), .readdata(readdata), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable));
  // update pulses last one cycle, so latch them
  always @(posedge clk_sys) begin
    if (offset_update === 1'b1) saw_offset <= 1'b1;
    if (gain_update === 1'b1) saw_gain <= 1'b1;
  end
  task automatic end_sim();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [3:0] a, input logic wr, input logic [31:0] d,
                     output logic [31:0] q);
    logic ok;
    u_host.xfer(a, wr, d, (a == 4'h0) ? 4'h3 : 4'hF, q, ok);
    if (!ok) begin
      n_mismatch++;
      end_sim();
    end
    @(negedge clk_sys);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0, q);
    chk(q, exp);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    int k;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    rd(adc_mode_pkg::addr_config, 32'h01B0);
    rd(4'h2, 32'h0);
    chk(modulator_reset, 1);
    for (int m = 4; m < 8; m++) begin
      saw_offset = 1'b0;
      saw_gain = 1'b0;
      wr(adc_mode_pkg::addr_config, (32'(m) << 13) | 32'(m & 3));
      chk(ready_n, 1);
      chk(cal_channel, m & 3);
      chk(cal_zero_input, m == 4);
      chk(cal_full_input, m == 5);
      rd(adc_mode_pkg::addr_status, 32'h9);
      // bus quiet, input held while calibrating
      for (k = 0; k < 100 && ready_n !== 1'b0; k++) @(negedge clk_sys);
      if (k == 100) begin
        n_mismatch++;
        end_sim();
      end
      // pulse latch needs one more edge
      @(negedge clk_sys);
      chk(saw_offset, m != 7);
      chk(saw_gain, m == 5 || m == 7);
      rd(adc_mode_pkg::addr_config, 32'(m & 3));
    end
    rd(adc_mode_pkg::addr_status, 32'h4);
    chk(irq, 0);
    rd(adc_mode_pkg::addr_irq_status, 32'h3);
    wr(adc_mode_pkg::addr_irq_mask, 32'h3);
    chk(irq, 1);
    wr(adc_mode_pkg::addr_irq_status, 32'h3);
    @(negedge clk_sys);
    chk(irq, 0);
    wr(adc_mode_pkg::addr_config, 32'h6000);
    chk(power_down, 1);
    wr(adc_mode_pkg::addr_config, 32'h0000);
    chk(power_down, 0);
    wr(adc_mode_pkg::addr_config, 32'h2000);
    chk(convert_enable, 1);
    chk(modulator_reset, 0);
    wr(adc_mode_pkg::addr_config, 32'h0000);
    chk(convert_enable, 0);
    @(posedge clk_sys);
    standby_pin <= 1'b1;
    repeat (10) @(negedge clk_sys);
    chk(power_down, 1);
    rd(adc_mode_pkg::addr_config, 32'h0);
    rd(adc_mode_pkg::addr_status, 32'h6);
    @(posedge clk_sys);
    standby_pin <= 1'b0;
    repeat (10) @(negedge clk_sys);
    chk(power_down, 0);
    wr(adc_mode_pkg::addr_config, 32'h1000);
    chk(unipolar_coding, 1);
    wr(adc_mode_pkg::addr_config, 32'h0000);
    chk(unipolar_coding, 0);
    wr(adc_mode_pkg::addr_config, 32'h0C00);
    chk({p1_oe, p0_oe, p1_o, p0_o}, 4'hE);
    wr(adc_mode_pkg::addr_config, 32'h0A00);
    chk({p1_oe, p0_oe, p1_o, p0_o}, 4'hD);
    wr(adc_mode_pkg::addr_config, 32'h0600);
    chk({p1_oe, p0_oe, p1_o, p0_o}, 4'h0);
    end_sim();
  end
endmodule
bind adc_mode_calibration_control adc_mode_checker #(.cal_cycles(cal_cycles)) u_chk (
  .clk_sys, .rst, .read, .write, .waitrequest, .standby_pin, .power_down,
  .modulator_reset, .convert_enable, .cal_zero_input, .cal_full_input, .offset_update,
  .gain_update, .ready_n, .shared_pin_port_bit1_o, .shared_pin_port_bit1_oe,
  .shared_pin_port_bit0_o, .shared_pin_port_bit0_oe);
